// ===== verilog/spi_sdc_pkg.sv
package spi_sdc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] DATA_OFS     = 8'h0c;
    localparam logic [7:0] POLY_OFS     = 8'h10;
    localparam logic [7:0] RECEIVE_CRC_VALUE_OFS    = 8'h14;
    localparam logic [7:0] TRANSMIT_CRC_VALUE_OFS    = 8'h18;

    // Reset values
    localparam logic [15:0] STATUS_RST  = 16'h0002;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam logic [15:0] POLY_RST    = 16'h0007;
    localparam logic [15:0] CRC_RST     = 16'h0000;
    localparam logic [6:0]  CTRL_RST    = 7'h00;

    // Control register bit positions
    localparam int CTRL_CRC_EN   = 0;
    localparam int CTRL_CRC_NEXT = 1;
    localparam int CTRL_RX_DMA   = 2;
    localparam int CTRL_ERR_IE   = 3;
    localparam int CTRL_FRAME16  = 4;
    localparam int CTRL_I2S      = 5;
    localparam int CTRL_PCM      = 6;
    localparam int CTRL_W        = 7;

    // Status register bit positions
    localparam int ST_RXNE       = 0;
    localparam int ST_TXE        = 1;
    localparam int ST_SIDE       = 2;
    localparam int ST_UDR        = 3;
    localparam int ST_CRCE       = 4;
    localparam int ST_MODF       = 5;
    localparam int ST_OVR        = 6;
    localparam int ST_BSY        = 7;
    localparam int ST_FRE        = 8;
    localparam int ST_RXLVL_LO   = 9;
    localparam int ST_TXLVL_LO   = 11;

    // Fill level codes
    localparam logic [1:0] LVL_EMPTY = 2'h0;
    localparam logic [1:0] LVL_FULL  = 2'h3;

    // Frame lengths in bits
    localparam logic [4:0] BITS8     = 5'h08;
    localparam logic [4:0] BITS16    = 5'h10;

endpackage : spi_sdc_pkg

// ===== verilog/spi_status_data_crc_regs.sv
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Status bit 0 shows receive buffer holds unread data.
// - Status bit 1 shows transmit buffer is empty.
// - In I2S mode without PCM, status bit 2 gives channel side, 0 left, 1 right.
// - In I2S mode underrun sets bit 3, sticky until software clears.
// - In SPI mode CRC mismatch sets bit 4; writing zero clears it.
// - In SPI mode mode fault sets bit 5, sticky until cleared.
// - Receive overrun sets bit 6 in both modes, sticky until cleared.
// - Bit 7 is hardware busy, one during a transfer.
// - Frame format error sets bit 8; a status read clears it.
// - Bits 10:9 give receive fill level; zero in I2S or CRC mode.
// - Bits 12:11 give transmit fill level; unused in I2S mode.
// - After reset status reads 0x0002.
// - Data write loads transmit buffer; data read returns receive buffer.
// - Eight-bit frames use only the low byte; sixteen-bit frames all.
// - Writable 16-bit CRC polynomial, reset 0x0007, used by both CRCs.
// - Receive CRC accumulates, eight or sixteen bits by frame length.
// - Setting CRC enable clears the receive CRC.
// - Transmit CRC accumulates, eight or sixteen bits by frame length.
// - With receive DMA on, a request fires when receive data arrives.
// - With error interrupt on, any error flag raises the interrupt.
module spi_status_data_crc_regs (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Serial link pins, slave mode 0
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic        ws_i,
    output logic             miso_o,
    // Events from the rest of the unit
    input  wire logic        mode_fault_evt_i,
    input  wire logic        frame_err_evt_i,
    // Requests to the system
    output logic             rx_dma_req_o,
    output logic             irq_o
);

    typedef struct packed {
        logic                         ack;
        logic [31:0]                  rdat;
        logic [spi_sdc_pkg::CTRL_W-1:0] ctrl;
        logic [15:0]                  rx_buf;
        logic                         rx_full;
        logic [15:0]                  tx_buf;
        logic                         tx_full;
        logic [15:0]                  sh_rx;
        logic [15:0]                  sh_tx;
        logic [4:0]                   bitcnt;
        logic                         busy;
        logic                         side;
        logic                         crc_frame;
        logic                         udr;
        logic                         crce;
        logic                         modf;
        logic                         ovr;
        logic                         fre;
        logic [15:0]                  poly;
        logic [15:0]                  receive_crc_value;
        logic [15:0]                  transmit_crc_value;
        logic                         miso;
        logic                         dma_req;
        logic                         irq;
        logic [1:0]                   sck_s;
        logic                         sck_d;
        logic [1:0]                   cs_s;
        logic                         cs_d;
        logic [1:0]                   mosi_s;
        logic [1:0]                   ws_s;
    } state_t;

    state_t r;
    state_t n;

    // One CRC bit step, MSB first, width chosen by frame length
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic        din,
                                             input logic [15:0] poly,
                                             input logic        w16);
        logic        fb;
        logic [15:0] res;
        fb  = (w16 ? crc[15] : crc[7]) ^ din;
        res = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
        if (!w16) begin
            res[15:8] = 8'h00;
        end
        return res;
    endfunction : crc_step

    logic        w16;
    logic [4:0]  flen;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_act;
    logic        frm_start;
    logic        frm_done;
    logic        err_any;
    logic [15:0] status;
    logic [15:0] rx_word;
    logic [15:0] wdat;

    // Decode, status assembly and next state
    always_comb begin
        n         = r;
        w16       = r.ctrl[spi_sdc_pkg::CTRL_FRAME16];
        flen      = w16 ? spi_sdc_pkg::BITS16 : spi_sdc_pkg::BITS8;
        acc       = wb_cyc_i & wb_stb_i & ~r.ack;
        wr        = acc & wb_we_i & wb_sel_i[0];
        rd        = acc & ~wb_we_i;
        wdat      = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};
        sck_rise  = r.sck_s[1] & ~r.sck_d;
        sck_fall  = ~r.sck_s[1] & r.sck_d;
        cs_act    = ~r.cs_s[1];
        frm_start = cs_act & r.cs_d;
        frm_done  = r.busy & sck_rise & (r.bitcnt == flen - 5'h01);
        rx_word   = w16 ? {r.sh_rx[14:0], r.mosi_s[1]}
                        : {8'h00, r.sh_rx[6:0], r.mosi_s[1]};

        // Status word as software sees it
        status                            = spi_sdc_pkg::STATUS_RST;
        status[spi_sdc_pkg::ST_RXNE]      = r.rx_full;
        status[spi_sdc_pkg::ST_TXE]       = ~r.tx_full;
        status[spi_sdc_pkg::ST_SIDE]      = r.side;
        status[spi_sdc_pkg::ST_UDR]       = r.udr;
        status[spi_sdc_pkg::ST_CRCE]      = r.crce;
        status[spi_sdc_pkg::ST_MODF]      = r.modf;
        status[spi_sdc_pkg::ST_OVR]       = r.ovr;
        status[spi_sdc_pkg::ST_BSY]       = r.busy;
        status[spi_sdc_pkg::ST_FRE]       = r.fre;
        // Receive level hidden in I2S mode and with CRC checking on
        status[spi_sdc_pkg::ST_RXLVL_LO +: 2] =
            (r.ctrl[spi_sdc_pkg::CTRL_I2S] | r.ctrl[spi_sdc_pkg::CTRL_CRC_EN]
             | ~r.rx_full) ? spi_sdc_pkg::LVL_EMPTY
                           : spi_sdc_pkg::LVL_FULL;
        // Single-entry buffer: one word counts as full
        status[spi_sdc_pkg::ST_TXLVL_LO +: 2] =
            (r.ctrl[spi_sdc_pkg::CTRL_I2S] | ~r.tx_full)
            ? spi_sdc_pkg::LVL_EMPTY : spi_sdc_pkg::LVL_FULL;

        // Input synchronisers and edge history
        n.sck_s  = {r.sck_s[0], sck_i};
        n.sck_d  = r.sck_s[1];
        n.cs_s   = {r.cs_s[0], cs_n_i};
        n.cs_d   = r.cs_s[1];
        n.mosi_s = {r.mosi_s[0], mosi_i};
        n.ws_s   = {r.ws_s[0], ws_i};

        // Bus answer, one cycle after the request is seen
        n.ack  = acc;
        n.rdat = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                spi_sdc_pkg::CTRL_OFS:
                    n.rdat = {25'h0, r.ctrl};
                spi_sdc_pkg::STATUS_OFS:
                    n.rdat = {16'h0000, status};
                spi_sdc_pkg::DATA_OFS:
                    n.rdat = {16'h0000, r.rx_buf};
                spi_sdc_pkg::POLY_OFS:
                    n.rdat = {16'h0000, r.poly};
                spi_sdc_pkg::RECEIVE_CRC_VALUE_OFS:
                    n.rdat = {16'h0000, r.receive_crc_value};
                spi_sdc_pkg::TRANSMIT_CRC_VALUE_OFS:
                    n.rdat = {16'h0000, r.transmit_crc_value};
                default:
                    n.rdat = 32'h0000_0000;
            endcase
        end

        // Software side: clears first, hardware sets later win
        if (rd && wb_adr_i == spi_sdc_pkg::DATA_OFS) begin
            n.rx_full = 1'b0;
        end
        if (rd && wb_adr_i == spi_sdc_pkg::STATUS_OFS) begin
            n.fre = 1'b0;
        end
        if (wr) begin
            case (wb_adr_i)
                spi_sdc_pkg::CTRL_OFS: begin
                    n.ctrl = wb_dat_i[spi_sdc_pkg::CTRL_W-1:0];
                    // Clear only as the enable turns on, so that a
                    // write that arms the CRC frame keeps the results
                    if (wb_dat_i[spi_sdc_pkg::CTRL_CRC_EN]
                        && !r.ctrl[spi_sdc_pkg::CTRL_CRC_EN]) begin
                        n.receive_crc_value = spi_sdc_pkg::CRC_RST;
                        n.transmit_crc_value = spi_sdc_pkg::CRC_RST;
                    end
                end
                spi_sdc_pkg::STATUS_OFS: begin
                    // Only the sticky error bits react, to a zero
                    if (!wb_dat_i[spi_sdc_pkg::ST_UDR]) n.udr = 1'b0;
                    if (!wb_dat_i[spi_sdc_pkg::ST_CRCE]) n.crce = 1'b0;
                    if (!wb_dat_i[spi_sdc_pkg::ST_MODF]) n.modf = 1'b0;
                    if (!wb_dat_i[spi_sdc_pkg::ST_OVR]) n.ovr = 1'b0;
                end
                spi_sdc_pkg::DATA_OFS: begin
                    n.tx_buf  = w16 ? wdat : {8'h00, wdat[7:0]};
                    n.tx_full = 1'b1;
                end
                spi_sdc_pkg::POLY_OFS:
                    n.poly = wdat;
                default: begin
                end
            endcase
        end

        // Transfer start: capture channel side, load transmit word
        if (frm_start || (frm_done && cs_act)) begin
            n.busy      = 1'b1;
            n.bitcnt    = 5'h00;
            n.crc_frame = r.ctrl[spi_sdc_pkg::CTRL_CRC_EN]
                        & r.ctrl[spi_sdc_pkg::CTRL_CRC_NEXT]
                        & ~r.ctrl[spi_sdc_pkg::CTRL_I2S];
            n.side      = r.ctrl[spi_sdc_pkg::CTRL_I2S]
                        & ~r.ctrl[spi_sdc_pkg::CTRL_PCM] & r.ws_s[1];
            if (n.crc_frame) begin
                n.sh_tx = w16 ? r.transmit_crc_value : {r.transmit_crc_value[7:0], 8'h00};
            end else if (r.tx_full || (wr && wb_adr_i ==
                                       spi_sdc_pkg::DATA_OFS)) begin
                n.sh_tx   = w16 ? n.tx_buf : {n.tx_buf[7:0], 8'h00};
                n.tx_full = 1'b0;
            end else begin
                n.sh_tx = 16'h0000;
                if (r.ctrl[spi_sdc_pkg::CTRL_I2S]) begin
                    n.udr = 1'b1;
                end
            end
            n.miso = n.sh_tx[15];
        end else if (!cs_act) begin
            n.busy = 1'b0;
        end

        // Rising edge: sample data and advance both CRCs
        if (r.busy && cs_act && sck_rise && !frm_done) begin
            n.sh_rx  = {r.sh_rx[14:0], r.mosi_s[1]};
            n.bitcnt = r.bitcnt + 5'h01;
        end
        if (r.busy && cs_act && sck_rise && !r.crc_frame
            && r.ctrl[spi_sdc_pkg::CTRL_CRC_EN]) begin
            n.receive_crc_value = crc_step(r.receive_crc_value, r.mosi_s[1], r.poly, w16);
            n.transmit_crc_value = crc_step(r.transmit_crc_value, r.miso, r.poly, w16);
        end
        // Falling edge: present next transmit bit
        if (r.busy && cs_act && sck_fall) begin
            n.sh_tx = {r.sh_tx[14:0], 1'b0};
            n.miso  = r.sh_tx[14];
        end

        // Frame end: store received word or flag the loss
        if (frm_done) begin
            if (r.crc_frame) begin
                n.ctrl[spi_sdc_pkg::CTRL_CRC_NEXT] = 1'b0;
                if (rx_word != (w16 ? r.receive_crc_value : {8'h00, r.receive_crc_value[7:0]})) begin
                    n.crce = 1'b1;
                end
            end
            if (r.rx_full && !(rd && wb_adr_i == spi_sdc_pkg::DATA_OFS)) begin
                n.ovr = 1'b1;
            end else begin
                n.rx_buf  = rx_word;
                n.rx_full = 1'b1;
            end
            if (!cs_act) begin
                n.busy = 1'b0;
            end
        end

        // Events reported by the rest of the unit
        if (mode_fault_evt_i && !r.ctrl[spi_sdc_pkg::CTRL_I2S]) begin
            n.modf = 1'b1;
        end
        if (frame_err_evt_i) begin
            n.fre = 1'b1;
        end

        // DMA request pulse on receive data arriving
        n.dma_req = n.rx_full & ~r.rx_full
                  & r.ctrl[spi_sdc_pkg::CTRL_RX_DMA];
        // Error request follows the sticky error flags
        err_any = n.udr | n.crce | n.modf | n.ovr | n.fre;
        n.irq   = err_any & n.ctrl[spi_sdc_pkg::CTRL_ERR_IE];
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r           <= '0;
            r.ctrl      <= spi_sdc_pkg::CTRL_RST;
            r.rx_buf    <= spi_sdc_pkg::DATA_RST;
            r.tx_buf    <= spi_sdc_pkg::DATA_RST;
            r.poly      <= spi_sdc_pkg::POLY_RST;
            r.receive_crc_value     <= spi_sdc_pkg::CRC_RST;
            r.transmit_crc_value     <= spi_sdc_pkg::CRC_RST;
            r.sck_s     <= 2'h0;
            r.cs_s      <= 2'h3;
            r.cs_d      <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o     = r.rdat;
    assign wb_ack_o     = r.ack;
    assign miso_o       = r.miso;
    assign rx_dma_req_o = r.dma_req;
    assign irq_o        = r.irq;

endmodule : spi_status_data_crc_regs

// ===== dv/spi_sdc_properties.sv
`timescale 1ns/1ps
module spi_sdc_properties (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Link, events and requests
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic        ws_i,
    input  wire logic        miso_o,
    input  wire logic        mode_fault_evt_i,
    input  wire logic        frame_err_evt_i,
    input  wire logic        rx_dma_req_o,
    input  wire logic        irq_o
);
    logic [6:0] ctl_r;
    logic       poly_wr_r;
    logic [7:0] adr_r;
    logic       we_r;
    logic       cs_q_r;
    logic [3:0] run_r;
    logic       rd_st;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Shadow of control bits and of the request now answered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r     <= 7'h00;
            poly_wr_r <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            adr_r <= wb_adr_i;
            we_r  <= wb_we_i;
            if (wb_we_i && wb_sel_i[0]
                && wb_adr_i == spi_sdc_pkg::CTRL_OFS) begin
                ctl_r <= wb_dat_i[6:0];
            end
            if (wb_we_i && wb_adr_i == spi_sdc_pkg::POLY_OFS) begin
                poly_wr_r <= 1'b1;
            end
        end
    end

    // Cycles spent at the present chip-select level
    always_ff @(posedge clk_i) begin
        cs_q_r <= cs_n_i;
        if (rst_i || cs_n_i != cs_q_r) begin
            run_r <= 4'h0;
        end else if (run_r != 4'hf) begin
            run_r <= run_r + 4'h1;
        end
    end

    assign rd_st = wb_ack_o && !we_r && adr_r == spi_sdc_pkg::STATUS_OFS;

    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ans_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    ack_resp_a: assert property (req_s |=> ans_s)
        else $error("bus answer not a single ack");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    dma_pulse_a: assert property (rx_dma_req_o |=> !rx_dma_req_o)
        else $error("dma request longer than one cycle");
    dma_enable_a: assert property (rx_dma_req_o |-> ctl_r[2])
        else $error("dma request while disabled");
    fault_irq_a: assert property ((mode_fault_evt_i && ctl_r[3]
        && !ctl_r[5]) |-> ##[1:3] irq_o)
        else $error("mode fault raised no interrupt");
    frame_irq_a: assert property ((frame_err_evt_i && ctl_r[3])
        |-> ##[1:3] irq_o)
        else $error("frame error raised no interrupt");
    status_resv_a: assert property (rd_st |-> wb_dat_o[31:13] == 19'h0)
        else $error("reserved status bits set");
    poly_reset_a: assert property ((wb_ack_o && !we_r && !poly_wr_r
        && adr_r == spi_sdc_pkg::POLY_OFS) |-> wb_dat_o == 32'h7)
        else $error("polynomial reset value wrong");
    data_low_a: assert property ((wb_ack_o && !we_r && !ctl_r[4]
        && adr_r == spi_sdc_pkg::DATA_OFS) |-> wb_dat_o[15:8] == 8'h0)
        else $error("upper byte used in byte frames");
    busy_flag_a: assert property ((rd_st && !cs_q_r && run_r > 4'h5)
        |-> wb_dat_o[7])
        else $error("busy clear inside a frame");
    idle_flag_a: assert property ((rd_st && cs_q_r && run_r > 4'h8)
        |-> !wb_dat_o[7])
        else $error("busy set while idle");
endmodule : spi_sdc_properties

// ===== dv/spi_link_master.sv
`timescale 1ns/1ps
module spi_link_master (
    // Link pins driven
    output logic            sck_o,
    output logic            cs_n_o,
    output logic            mosi_o,
    output logic            ws_o,
    // Link pin sampled
    input  wire logic       miso_i
);
    // Idle link: clock low, not selected
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        ws_o = 1'b0;
    end

    // One mode 0 frame, MSB first, 80 ns link period, own phase
    task automatic frame(input logic [15:0] tx, input int nb,
                         input logic ws, output logic [15:0] rx);
        rx = 16'h0000;
        ws_o = ws;
        #1.3 cs_n_o = 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            mosi_o = tx[i];
            #40 sck_o = 1'b1;
            rx = {rx[14:0], miso_i};
            #40 sck_o = 1'b0;
        end
        #40 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale bit
    endtask : frame
endmodule : spi_link_master

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0] v;
        logic [15:0] m;
    } note_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sck_i;
    logic        cs_n_i;
    logic        mosi_i;
    logic        ws_i;
    logic        miso_o;
    logic        mode_fault_evt_i = 1'b0;
    logic        frame_err_evt_i = 1'b0;
    logic        rx_dma_req_o;
    logic        irq_o;
    note_t       q[$];
    int          err_count = 0;
    int          checked = 0;
    int          dma_n = 0;
    logic [15:0] p, t, m, c_rx, c_tx;

    // 250 MHz clock
    always #2 clk_i = ~clk_i;

    spi_status_data_crc_regs dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .sck_i, .cs_n_i, .mosi_i, .ws_i, .miso_o, .mode_fault_evt_i,
        .frame_err_evt_i, .rx_dma_req_o, .irq_o);
    spi_link_master lnk (.sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
        .ws_o(ws_i), .miso_i(miso_o));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic fail(input string s);
        err_count++;
        $display("wrong value at %0t: %s", $time, s);
    endtask : fail

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) fail($sformatf("got %h expected %h", g, e));
    endtask : chk

    // Classic single cycle; read notes its expectation first
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [15:0] k);
        int n;
        n = 0;
        @(posedge clk_i);
        if (!w) q.push_back(note_t'{d, k});
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {16'h0000, d};
        // Look at ack mid-cycle, release after the edge that saw it
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 64) begin
            fail("bus timeout");
            end_of_test();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 16'h0000);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] v,
                      input logic [15:0] k);
        bus(1'b0, a, v, k);
    endtask : rd

    task automatic link(input logic [15:0] mo, input int nb,
                        input logic w, input logic [15:0] e);
        logic [15:0] g;
        lnk.frame(mo, nb, w, g);
        chk(g, e);
        repeat (8) @(posedge clk_i);
    endtask : link

    task automatic pulse();
        @(posedge clk_i);
        mode_fault_evt_i <= 1'b1;
        frame_err_evt_i <= 1'b1;
        @(posedge clk_i);
        mode_fault_evt_i <= 1'b0;
        frame_err_evt_i <= 1'b0;
    endtask : pulse

    // Serial CRC, MSB first, byte frames keep the low byte
    function automatic logic [15:0] crc(input logic [15:0] d, input int nb);
        logic [15:0] c;
        logic        fb;
        c = 16'h0000;
        for (int i = nb - 1; i >= 0; i--) begin
            fb = c[nb-1] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? p : 16'h0000);
        end
        return (nb == 8) ? (c & 16'h00ff) : c;
    endfunction : crc

    // Read results against the oldest note; count dma pulses
    always @(negedge clk_i) begin
        if (rx_dma_req_o === 1'b1) dma_n++;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            checked++;
            if (q.size() == 0) begin
                fail("read with no note");
            end else begin
                if ((wb_dat_o[15:0] & q[0].m) !== (q[0].v & q[0].m))
                    fail($sformatf("read %h", wb_dat_o[15:0]));
                void'(q.pop_front());
            end
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'ha5b5));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0002, 16'hffff);
        rd(spi_sdc_pkg::POLY_OFS, 16'h0007, 16'hffff);
        rd(spi_sdc_pkg::RECEIVE_CRC_VALUE_OFS, 16'h0000, 16'hffff);
        rd(spi_sdc_pkg::TRANSMIT_CRC_VALUE_OFS, 16'h0000, 16'hffff);
        rd(8'h1c, 16'h0000, 16'hffff);
        p = 16'($urandom());
        wr(spi_sdc_pkg::POLY_OFS, p);
        rd(spi_sdc_pkg::POLY_OFS, p, 16'hffff);
        wr(spi_sdc_pkg::STATUS_OFS, 16'hffff);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0002, 16'hffff);
        $display("test reset done");
        wr(spi_sdc_pkg::CTRL_OFS, 16'h000c);
        t = 16'($urandom());
        m = 16'($urandom());
        wr(spi_sdc_pkg::DATA_OFS, t);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h1800, 16'h1803);
        fork
            link(m, 8, 1'b0, {8'h00, t[7:0]});
            begin
                repeat (40) @(posedge clk_i);
                rd(spi_sdc_pkg::STATUS_OFS, 16'h0080, 16'h0080);
            end
        join
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0603, 16'h1e83);
        rd(spi_sdc_pkg::DATA_OFS, {8'h00, m[7:0]}, 16'hffff);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0601);
        chk(16'(dma_n), 16'h0001);
        wr(spi_sdc_pkg::CTRL_OFS, 16'h001c);
        wr(spi_sdc_pkg::DATA_OFS, t);
        link(m, 16, 1'b0, t);
        rd(spi_sdc_pkg::DATA_OFS, m, 16'hffff);
        chk(16'(dma_n), 16'h0002);
        $display("test frames done");
        link(m, 16, 1'b0, 16'h0000);
        link(~m, 16, 1'b0, 16'h0000);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0040, 16'h0078);
        chk({15'h0, irq_o}, 16'h0001);
        rd(spi_sdc_pkg::DATA_OFS, m, 16'hffff);
        wr(spi_sdc_pkg::STATUS_OFS, 16'hffbf);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0040);
        chk({15'h0, irq_o}, 16'h0000);
        pulse();
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0120, 16'h0120);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0020, 16'h0120);
        wr(spi_sdc_pkg::STATUS_OFS, 16'hffdf);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0020);
        $display("test flags done");
        wr(spi_sdc_pkg::CTRL_OFS, 16'h0001);
        wr(spi_sdc_pkg::DATA_OFS, t);
        link(m, 8, 1'b0, {8'h00, t[7:0]});
        rd(spi_sdc_pkg::DATA_OFS, {8'h00, m[7:0]}, 16'hffff);
        c_rx = crc(m, 8);
        c_tx = crc(t, 8);
        rd(spi_sdc_pkg::RECEIVE_CRC_VALUE_OFS, c_rx, 16'hffff);
        rd(spi_sdc_pkg::TRANSMIT_CRC_VALUE_OFS, c_tx, 16'hffff);
        wr(spi_sdc_pkg::CTRL_OFS, 16'h0003);
        link(~c_rx, 8, 1'b0, c_tx);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0010, 16'h0010);
        rd(spi_sdc_pkg::DATA_OFS, 16'h0000, 16'h0000);
        wr(spi_sdc_pkg::STATUS_OFS, 16'hffef);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0010);
        wr(spi_sdc_pkg::CTRL_OFS, 16'h0000);
        wr(spi_sdc_pkg::CTRL_OFS, 16'h0001);
        rd(spi_sdc_pkg::RECEIVE_CRC_VALUE_OFS, 16'h0000, 16'hffff);
        $display("test crc done");
        wr(spi_sdc_pkg::CTRL_OFS, 16'h0030);
        link(m, 16, 1'b1, 16'h0000);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h000d, 16'h060d);
        rd(spi_sdc_pkg::DATA_OFS, m, 16'hffff);
        wr(spi_sdc_pkg::STATUS_OFS, 16'hfff7);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0008);
        link(m, 16, 1'b0, 16'h0000);
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0009, 16'h000d);
        pulse();
        rd(spi_sdc_pkg::STATUS_OFS, 16'h0000, 16'h0020);
        $display("test audio done");
        end_of_test();
    end
endmodule : tb

bind spi_status_data_crc_regs spi_sdc_properties chk (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sck_i, .cs_n_i, .mosi_i, .ws_i, .miso_o,
    .mode_fault_evt_i, .frame_err_evt_i, .rx_dma_req_o, .irq_o);
